// File: sba_regs.svh
// constants for the shared bus arbitration block of a four-processor module
// assumes one clock, clk_sys, common to every processor and to the bus pins
`ifndef SBA_REGS_SVH
`define SBA_REGS_SVH
`define SBA_NPROC 4
`define SBA_NLINES 6
`define SBA_IDW 3
`define SBA_ID_SINGLE 3'h0
`endif

// File: sba_pkg.sv
// types and decode helpers for the shared bus arbitration block
// assumes sba_regs.svh is on the include path
`include "sba_regs.svh"
package sba_pkg;
    typedef enum logic [0:0] {
        SBA_ST_ARB = 1'b0,
        SBA_ST_HOST = 1'b1
    } sba_state_t;

    typedef logic [`SBA_NLINES-1:0] sba_lines_t;

    // processor number to one-hot request line; single-processor code maps to none
    function automatic sba_lines_t sba_id_line(input logic [`SBA_IDW-1:0] id);
        sba_lines_t r;
        r = '0;
        for (int k = 0; k < `SBA_NLINES; k++) begin
            if (id == 3'(k + 1)) begin
                r[k] = 1'b1;
            end
        end
        return r;
    endfunction : sba_id_line
endpackage : sba_pkg

// File: sba_pick.sv
// request line picker: fixed (lowest line first) or rotating after last owner
// assumes the request vector is already active high
`timescale 1ns/1ps
`default_nettype none
module sba_pick import sba_pkg::*; #(
    parameter int N = `SBA_NLINES
) (
    input wire logic [N-1:0] req,
    input wire logic rotate,
    input wire logic [2:0] last,
    output logic win_valid,
    output logic [2:0] win_idx
);
    // walk from the far end so the first candidate in priority order wins
    always_comb begin
        win_valid = 1'b0;
        win_idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            int j;
            j = rotate ? (int'(last) + 1 + i) % N : i;
            if (req[j]) begin
                win_valid = 1'b1;
                win_idx = 3'(j);
            end
        end
    end
endmodule : sba_pick
`default_nettype wire

// File: sba_ready_drv.sv
// host ready pin driver, open drain unless active drive is selected
// assumes ready and enable terms are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module sba_ready_drv (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic active,
    input wire logic ready,
    input wire logic drive_sel,
    output logic pin_o,
    output logic pin_oe
);
    // open drain only pulls low; active drive also drives the high level
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_o <= drive_sel & ready;
            pin_oe <= active & (drive_sel | ~ready);
        end
    end
endmodule : sba_ready_drv
`default_nettype wire

// File: sba_arbiter.sv
// shared external bus control for four internal processors
// assumes all pin inputs are synchronous to clk_sys and pins are resolved outside
`timescale 1ns/1ps
`default_nettype none
module sba_arbiter import sba_pkg::*; #(
    parameter int NPROC = `SBA_NPROC,
    parameter int NLINES = `SBA_NLINES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    // configuration straps, one number per processor
    input wire logic [NPROC*3-1:0] processor_number,
    input wire logic rotating_priority_sel,
    input wire logic [NPROC-1:0] ready_active_drive_sel,
    // core side requests
    input wire logic [NPROC-1:0] core_bus_req,
    input wire logic [NPROC-1:0] dma_bus_req,
    input wire logic [NPROC-1:0] core_prio_req,
    input wire logic [NPROC-1:0] host_wait,
    // shared pins
    input wire logic bus_suspend_n,
    input wire logic host_bus_request_n,
    input wire logic host_select_0_n,
    input wire logic host_select_1_n,
    input wire logic host_select_2_n,
    input wire logic host_select_3_n,
    input wire logic host_bus_grant_n_i,
    output logic host_bus_grant_n_o,
    output logic host_bus_grant_n_oe,
    input wire logic [NLINES-1:0] proc_bus_request_n_i,
    output logic [NLINES-1:0] proc_bus_request_n_o,
    output logic [NLINES-1:0] proc_bus_request_n_oe,
    input wire logic core_priority_line_n_i,
    output logic [NPROC-1:0] core_priority_line_n_o,
    output logic [NPROC-1:0] core_priority_line_n_oe,
    input wire logic dma_request_ch7_n,
    input wire logic dma_request_ch8_n,
    output logic dma_grant_ch7_n,
    output logic dma_grant_ch8_n,
    output logic host_access_ready_o,
    output logic host_access_ready_oe,
    // status toward the cores and the pad ring
    output logic bus_drive_en,
    output logic [NPROC-1:0] bus_owner,
    output logic [NPROC-1:0] core_stall
);
    sba_state_t st_q;
    logic [2:0] master_q;
    logic master_vld_q;
    logic [NLINES-1:0] obs_req;
    logic [NLINES-1:0] own_lines;
    logic [NLINES-1:0] line_want;
    logic [NLINES-1:0] id_line [NPROC];
    logic [NPROC-1:0] own_c;
    logic [NPROC-1:0] want_c;
    logic [NPROC-1:0] go_c;
    logic [3:0] cs_vec;
    logic host_req;
    logic win_valid;
    logic [2:0] win_idx;
    logic bus_free;
    logic host_active;
    logic [1:0] sel_idx;

    assign host_req = ~host_bus_request_n;
    assign obs_req = ~proc_bus_request_n_i;
    assign cs_vec = ~{host_select_3_n, host_select_2_n, host_select_1_n, host_select_0_n};

    // one decoded request line per processor, shared by every use below
    genvar g;
    generate
        for (g = 0; g < NPROC; g++) begin : g_id
            assign id_line[g] = sba_id_line(processor_number[g*3 +: 3]);
        end
    endgenerate

    // per processor wants, line ownership and access permission
    always_comb begin
        own_lines = '0;
        line_want = '0;
        for (int p = 0; p < NPROC; p++) begin
            // core priority from any slave pushes background DMA aside
            want_c[p] = core_bus_req[p] | (dma_bus_req[p] & core_priority_line_n_i);
            line_want = line_want | (want_c[p] ? id_line[p] : '0);
            own_c[p] = master_vld_q & id_line[p][master_q];
            own_lines = own_lines | id_line[p];
        end
    end

    // the bus is usable only when owned, not hosted and not suspended
    assign bus_free = (|own_c) & (st_q == SBA_ST_ARB) & ~host_req & bus_suspend_n;
    assign go_c = own_c & core_bus_req & {NPROC{bus_free}};

    sba_pick #(
        .N(NLINES)
    ) u_pick (
        .req(obs_req),
        .rotate(rotating_priority_sel),
        .last(master_q),
        .win_valid(win_valid),
        .win_idx(win_idx)
    );

    // host tenure: enter on request, leave on release
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_q <= SBA_ST_ARB;
        end else begin
            case (st_q)
                SBA_ST_ARB: begin
                    if (host_req) begin
                        st_q <= SBA_ST_HOST;
                    end
                end
                SBA_ST_HOST: begin
                    if (!host_req) begin
                        st_q <= SBA_ST_ARB;
                    end
                end
                default: begin
                    st_q <= SBA_ST_ARB;
                end
            endcase
        end
    end

    // mastership is parked: it moves only when the owner lets its line go,
    // and stays frozen through host tenure so the old owner resumes first
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            master_q <= '0;
            master_vld_q <= 1'b0;
        end else if (st_q == SBA_ST_ARB && !host_req) begin
            if (!master_vld_q || !obs_req[master_q]) begin
                // an empty round keeps the old index so rotation resumes after it
                master_q <= win_valid ? win_idx : master_q;
                master_vld_q <= win_valid;
            end
        end
    end

    // request lines: only our own numbered lines are ever driven, always low
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            proc_bus_request_n_o <= '0;
            proc_bus_request_n_oe <= '0;
        end else begin
            proc_bus_request_n_o <= '0;
            proc_bus_request_n_oe <= line_want & own_lines;
        end
    end

    // host grant is driven only by the processor that owns the bus
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            host_bus_grant_n_o <= 1'b1;
            host_bus_grant_n_oe <= 1'b0;
        end else begin
            host_bus_grant_n_o <= ~((st_q == SBA_ST_HOST) & host_req);
            host_bus_grant_n_oe <= |own_c;
        end
    end

    // pad enable for address, data, selects and strobes
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bus_drive_en <= 1'b0;
        end else begin
            bus_drive_en <= bus_free;
        end
    end

    // owner and stall status toward the cores
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bus_owner <= '0;
            core_stall <= '0;
        end else begin
            bus_owner <= own_c;
            core_stall <= core_bus_req & ~go_c;
        end
    end

    // core priority pins: open drain, pulled low by a requesting slave
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            core_priority_line_n_o <= '0;
            core_priority_line_n_oe <= '0;
        end else begin
            core_priority_line_n_o <= '0;
            core_priority_line_n_oe <= core_prio_req & ~own_c;
        end
    end

    // shared DMA grants; channel seven outranks eight, one grant at a time
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dma_grant_ch7_n <= 1'b1;
            dma_grant_ch8_n <= 1'b1;
        end else begin
            dma_grant_ch7_n <= ~(bus_free & ~dma_request_ch7_n);
            dma_grant_ch8_n <= ~(bus_free & dma_request_ch7_n & ~dma_request_ch8_n);
        end
    end

    // host access ready: selected processor, only with select and request low
    always_comb begin
        sel_idx = 2'h0;
        for (int p = 3; p >= 0; p--) begin
            if (cs_vec[p]) begin
                sel_idx = 2'(p);
            end
        end
    end
    assign host_active = host_req & (|cs_vec);

    sba_ready_drv u_ready (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .active(host_active),
        .ready(~host_wait[sel_idx]),
        .drive_sel(ready_active_drive_sel[sel_idx]),
        .pin_o(host_access_ready_o),
        .pin_oe(host_access_ready_oe)
    );

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_host_held;
        !host_bus_request_n ##1 !host_bus_request_n;
    endsequence
    sequence s_host_release;
        st_q == SBA_ST_HOST ##1 st_q == SBA_ST_ARB;
    endsequence
    sequence s_host_enter;
        (st_q == SBA_ST_ARB) && host_req ##1 host_req;
    endsequence

    property p_host_enter;
        s_host_enter |=> !host_bus_grant_n_o;
    endproperty
    a_host_enter: assert property (p_host_enter)
        else $error("host grant not given after request");

    property p_grant_release;
        (st_q == SBA_ST_HOST) && !host_req |=> host_bus_grant_n_o;
    endproperty
    a_grant_release: assert property (p_grant_release)
        else $error("host grant kept after release");

    property p_free_drive;
        bus_free |=> bus_drive_en;
    endproperty
    a_free_drive: assert property (p_free_drive)
        else $error("owner not driving a free bus");

    property p_fixed_low;
        !rotating_priority_sel && win_valid |->
            (obs_req & ((NLINES'(1) << win_idx) - NLINES'(1))) == '0;
    endproperty
    a_fixed_low: assert property (p_fixed_low)
        else $error("fixed priority skipped a lower line");

    property p_dma_seven;
        !dma_request_ch7_n && bus_free |=> !dma_grant_ch7_n;
    endproperty
    a_dma_seven: assert property (p_dma_seven)
        else $error("channel seven not granted");

    property p_dma_eight;
        dma_request_ch7_n && !dma_request_ch8_n && bus_free |=> !dma_grant_ch8_n;
    endproperty
    a_dma_eight: assert property (p_dma_eight)
        else $error("channel eight not granted");

    property p_ready_off;
        !host_active |=> !host_access_ready_oe;
    endproperty
    a_ready_off: assert property (p_ready_off)
        else $error("ready driven while host idle");

    property p_ready_open;
        host_active && !ready_active_drive_sel[sel_idx] |=> !host_access_ready_o;
    endproperty
    a_ready_open: assert property (p_ready_open)
        else $error("open drain ready drove high");

    property p_ready_wait;
        host_active && host_wait[sel_idx] |=> host_access_ready_oe && !host_access_ready_o;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("wait state not inserted");

    property p_prio_mask;
        !core_priority_line_n_i |-> (want_c & ~core_bus_req) == '0;
    endproperty
    a_prio_mask: assert property (p_prio_mask)
        else $error("background transfer kept under core priority");

    property p_suspend_float;
        !bus_suspend_n |=> !bus_drive_en;
    endproperty
    a_suspend_float: assert property (p_suspend_float)
        else $error("bus driven after suspend");

    property p_suspend_stall;
        !bus_suspend_n |=> core_stall == $past(core_bus_req);
    endproperty
    a_suspend_stall: assert property (p_suspend_stall)
        else $error("access not stalled under suspend");

    property p_grant_held;
        s_host_held |=> !host_bus_grant_n_o;
    endproperty
    a_grant_held: assert property (p_grant_held)
        else $error("host grant dropped while request held");

    property p_host_float;
        st_q == SBA_ST_HOST |=> !bus_drive_en;
    endproperty
    a_host_float: assert property (p_host_float)
        else $error("bus driven during host tenure");

    property p_host_first;
        !host_bus_request_n |=> dma_grant_ch7_n && dma_grant_ch8_n && !bus_drive_en;
    endproperty
    a_host_first: assert property (p_host_first)
        else $error("processor side kept bus against host");

    property p_grant_owner;
        host_bus_grant_n_oe |-> $past(master_vld_q);
    endproperty
    a_grant_owner: assert property (p_grant_owner)
        else $error("host grant driven without bus ownership");

    property p_ready_gate;
        host_access_ready_oe |-> $past(host_active);
    endproperty
    a_ready_gate: assert property (p_ready_gate)
        else $error("ready driven without select and host request");

    property p_own_line;
        (proc_bus_request_n_oe & ~$past(own_lines)) == '0;
    endproperty
    a_own_line: assert property (p_own_line)
        else $error("foreign request line driven");

    property p_reclaim;
        s_host_release |-> master_q == $past(master_q);
    endproperty
    a_reclaim: assert property (p_reclaim)
        else $error("mastership moved across host tenure");

    property p_dma_one;
        !dma_grant_ch8_n |-> dma_grant_ch7_n && $past(dma_request_ch7_n);
    endproperty
    a_dma_one: assert property (p_dma_one)
        else $error("channel eight granted over channel seven");
endmodule : sba_arbiter
`default_nettype wire

// File: sba_far_model.sv
// far-side model: host pin driver and resolution of the shared wires
// assumes design enables are registered on clk_sys; idle wires read high
`timescale 1ns/1ps
`default_nettype none
module sba_far_model (
    input wire logic clk_sys,
    input wire logic host_want,
    input wire logic [3:0] host_pick,
    input wire logic [5:0] req_oe,
    input wire logic gnt_o,
    input wire logic gnt_oe,
    input wire logic [3:0] cpa_oe,
    output logic host_bus_request_n,
    output logic [3:0] host_select_n,
    output logic [5:0] req_wire_n,
    output logic gnt_wire_n,
    output logic cpa_wire_n
);
    initial begin
        host_bus_request_n = 1'b1;
        host_select_n = 4'hf;
    end
    // host moves its pins just after an edge, deadlock-free use of suspend only
    always @(posedge clk_sys) begin
        host_bus_request_n <= ~host_want;
        host_select_n <= ~host_pick;
    end
    // lines 1-4 held high by idle processors, 5-6 by pull-ups; straps fixed
    assign req_wire_n = ~req_oe;
    // a released grant wire floats back high through the host pull-up
    assign gnt_wire_n = gnt_oe ? gnt_o : 1'b1;
    assign cpa_wire_n = ~|cpa_oe;
endmodule : sba_far_model
`default_nettype wire

// File: sba_arbiter_tb.sv
// self-checking bench for the shared bus arbiter
// assumes the far-side model resolves the request, grant and core priority wires
`timescale 1ns/1ps
`default_nettype none
module sba_arbiter_tb import sba_pkg::*;;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic rotating_priority_sel = 1'b0;
    logic [11:0] pnum = 12'h8d1;
    logic [3:0] drive_sel = 4'h0;
    logic [3:0] core_bus_req = 4'h0;
    logic [3:0] dma_bus_req = 4'h0;
    logic [3:0] core_prio_req = 4'h0;
    logic [3:0] host_wait = 4'h0;
    logic [3:0] host_pick = 4'h0;
    logic host_want = 1'b0;
    logic bus_suspend_n = 1'b1;
    logic dma7_n = 1'b1;
    logic dma8_n = 1'b1;
    logic hbr_n, gnt_o, gnt_oe, gnt_wire, cpa_wire, g7, g8, rdy_o, rdy_oe, drive_en;
    logic [3:0] sel_n, cpa_o, cpa_oe, owner, stall;
    logic [5:0] req_o, req_oe, req_wire;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #2 clk_sys = ~clk_sys;

    sba_arbiter dut (.clk_sys(clk_sys), .nrst(nrst), .processor_number(pnum),
        .rotating_priority_sel(rotating_priority_sel), .ready_active_drive_sel(drive_sel),
        .core_bus_req(core_bus_req), .dma_bus_req(dma_bus_req), .core_prio_req(core_prio_req),
        .host_wait(host_wait), .bus_suspend_n(bus_suspend_n), .host_bus_request_n(hbr_n),
        .host_select_0_n(sel_n[0]), .host_select_1_n(sel_n[1]), .host_select_2_n(sel_n[2]),
        .host_select_3_n(sel_n[3]), .host_bus_grant_n_i(gnt_wire), .host_bus_grant_n_o(gnt_o),
        .host_bus_grant_n_oe(gnt_oe), .proc_bus_request_n_i(req_wire),
        .proc_bus_request_n_o(req_o), .proc_bus_request_n_oe(req_oe),
        .core_priority_line_n_i(cpa_wire), .core_priority_line_n_o(cpa_o),
        .core_priority_line_n_oe(cpa_oe), .dma_request_ch7_n(dma7_n),
        .dma_request_ch8_n(dma8_n), .dma_grant_ch7_n(g7), .dma_grant_ch8_n(g8),
        .host_access_ready_o(rdy_o), .host_access_ready_oe(rdy_oe), .bus_drive_en(drive_en),
        .bus_owner(owner), .core_stall(stall));

    sba_far_model far (.clk_sys(clk_sys), .host_want(host_want), .host_pick(host_pick),
        .req_oe(req_oe), .gnt_o(gnt_o), .gnt_oe(gnt_oe), .cpa_oe(cpa_oe),
        .host_bus_request_n(hbr_n), .host_select_n(sel_n), .req_wire_n(req_wire),
        .gnt_wire_n(gnt_wire), .cpa_wire_n(cpa_wire));

    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // sample one step after the edge so registered outputs have landed
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic req(input logic [3:0] v);
        @(posedge clk_sys) core_bus_req <= v;
        #1;
    endtask : req

    // bounded wait: a parked owner may need a few edges to hand over
    task automatic wait_owner(input logic [3:0] exp);
        for (int i = 0; i < 12 && owner !== exp; i++) tick();
        check(8'(owner), 8'(exp));
    endtask : wait_owner

    task automatic wait_hbr(input logic v);
        for (int i = 0; i < 4 && hbr_n !== v; i++) tick();
    endtask : wait_hbr

    task automatic t_reset();
        check({owner, 3'h0, drive_en}, 8'h00);
        check({rdy_oe, gnt_oe, gnt_o, g7, g8}, 8'h07);
    endtask : t_reset

    task automatic t_arbitrate();
        @(posedge clk_sys) rotating_priority_sel <= 1'b0;
        req(4'h2);
        wait_owner(4'h2);
        check({2'h0, req_oe}, 8'h02);
        check({stall, 3'h0, drive_en}, 8'h01);
        req(4'h0);
        tick(3);
        req(4'hc);
        wait_owner(4'h4);
        req(4'h0);
        tick(3);
        @(posedge clk_sys) rotating_priority_sel <= 1'b1;
        req(4'h9);
        wait_owner(4'h8);
        req(4'h0);
        @(posedge clk_sys) rotating_priority_sel <= 1'b0;
        tick(3);
    endtask : t_arbitrate

    task automatic t_host();
        req(4'h2);
        wait_owner(4'h2);
        @(posedge clk_sys) host_want <= 1'b1;
        #1;
        wait_hbr(1'b0);
        tick();
        check({7'h0, drive_en}, 8'h00);
        req(4'h3);
        check({gnt_oe, gnt_o}, 8'h02);
        repeat (5) begin
            check({gnt_o, drive_en}, 8'h00);
            tick();
        end
        @(posedge clk_sys) host_want <= 1'b0;
        #1;
        wait_hbr(1'b1);
        tick();
        check({7'h0, gnt_o}, 8'h01);
        wait_owner(4'h2);
        req(4'h0);
        tick(3);
    endtask : t_host

    task automatic t_suspend();
        req(4'h1);
        wait_owner(4'h1);
        @(posedge clk_sys) bus_suspend_n <= 1'b0;
        tick();
        repeat (3) begin
            check({stall, 3'h0, drive_en}, 8'h10);
            tick();
        end
        @(posedge clk_sys) bus_suspend_n <= 1'b1;
        tick(3);
        check({stall, 3'h0, drive_en}, 8'h01);
        req(4'h0);
        tick(3);
    endtask : t_suspend

    task automatic t_ready();
        @(posedge clk_sys) host_wait <= 4'h2;
        host_pick <= 4'h2;
        host_want <= 1'b1;
        tick(4);
        check({rdy_oe, rdy_o}, 8'h02);
        @(posedge clk_sys) host_wait <= 4'h0;
        tick(3);
        check({7'h0, rdy_oe}, 8'h00);
        @(posedge clk_sys) drive_sel <= 4'h2;
        tick(3);
        check({rdy_oe, rdy_o}, 8'h03);
        @(posedge clk_sys) host_pick <= 4'h0;
        tick(3);
        check({7'h0, rdy_oe}, 8'h00);
        @(posedge clk_sys) host_want <= 1'b0;
        drive_sel <= 4'h0;
        tick(4);
    endtask : t_ready

    task automatic t_dma_prio();
        // grants need an owner that can use the bus
        req(4'h1);
        wait_owner(4'h1);
        @(posedge clk_sys) dma7_n <= 1'b0;
        dma8_n <= 1'b0;
        for (int i = 0; i < 6 && g7 !== 1'b0; i++) tick();
        check({g7, g8}, 8'h01);
        @(posedge clk_sys) dma7_n <= 1'b1;
        for (int i = 0; i < 6 && g8 !== 1'b0; i++) tick();
        check({g7, g8}, 8'h02);
        @(posedge clk_sys) dma8_n <= 1'b1;
        core_bus_req <= 4'h0;
        core_prio_req <= 4'h8;
        dma_bus_req <= 4'h1;
        tick(3);
        check({cpa_oe, cpa_o}, 8'h80);
        check({7'h0, cpa_wire}, 8'h00);
        check({2'h0, req_oe}, 8'h00);
        @(posedge clk_sys) core_prio_req <= 4'h0;
        tick(3);
        check({2'h0, req_oe}, 8'h01);
        @(posedge clk_sys) dma_bus_req <= 4'h0;
        tick(3);
    endtask : t_dma_prio

    // hang guard, well above the 120 or so cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        tick();
        t_reset();
        t_arbitrate();
        t_host();
        t_suspend();
        t_ready();
        t_dma_prio();
        finish_test();
    end
endmodule : sba_arbiter_tb
`default_nettype wire
